// >>> cbtc_pkg.sv
// Constants and carrier types for the bit, transfer and control executor.
package cbtc_pkg;

  localparam logic [7:0] ADDR_INSTR = 8'h00;
  localparam logic [7:0] ADDR_EXT = 8'h04;
  localparam logic [7:0] ADDR_FLAGS = 8'h08;
  localparam logic [7:0] ADDR_SP = 8'h0C;
  localparam logic [7:0] ADDR_GPR_SEL = 8'h10;
  localparam logic [7:0] ADDR_GPR_DATA = 8'h14;
  localparam logic [7:0] ADDR_STATUS = 8'h18;

  localparam logic [7:0] FLAGS_RST = 8'h00;
  localparam logic [15:0] SP_RST = 16'h00FF;
  localparam logic [7:0] GPR_RST = 8'h00;

  localparam int FLAG_C = 0;
  localparam int FLAG_Z = 1;
  localparam int FLAG_N = 2;
  localparam int FLAG_V = 3;
  localparam int FLAG_S = 4;
  localparam int FLAG_H = 5;
  localparam int FLAG_T = 6;
  localparam int FLAG_I = 7;

  localparam logic [1:0] CYC_ONE = 2'h1;
  localparam logic [1:0] CYC_MEM = 2'h2;
  localparam logic [1:0] CYC_PM = 2'h3;

  localparam logic [1:0] PTR_X = 2'h1;
  localparam logic [1:0] PTR_Y = 2'h2;
  localparam logic [1:0] PTR_Z = 2'h3;
  localparam logic [4:0] REG_X_LO = 5'h1A;
  localparam logic [4:0] REG_Y_LO = 5'h1C;
  localparam logic [4:0] REG_Z_LO = 5'h1E;
  localparam logic [4:0] REG_ZERO = 5'h00;

  localparam logic [1:0] MODE_PLAIN = 2'h0;
  localparam logic [1:0] MODE_POST_INC = 2'h1;
  localparam logic [1:0] MODE_PRE_DEC = 2'h2;
  localparam logic [1:0] MODE_TO_R0 = 2'h3;

  typedef enum logic [4:0] {
    OP_NOP = 5'h00, OP_SIGNED_SHIFT_RIGHT = 5'h01, OP_NIBBLE_SWAP = 5'h02,
    OP_FLAG_SET = 5'h03, OP_FLAG_CLEAR = 5'h04, OP_BIT_TO_TRANSFER_FLAG = 5'h05,
    OP_TRANSFER_FLAG_TO_BIT = 5'h06, OP_COPY = 5'h07, OP_REGISTER_PAIR_COPY = 5'h08,
    OP_MEM_READ_IND = 5'h09, OP_MEM_WRITE_IND = 5'h0A, OP_READ_DISP_Y = 5'h0B,
    OP_READ_DISP_Z = 5'h0C, OP_WRITE_DISP_Y = 5'h0D, OP_WRITE_DISP_Z = 5'h0E,
    OP_MEM_READ_DIRECT = 5'h0F, OP_MEM_WRITE_DIRECT = 5'h10,
    OP_PROGRAM_MEMORY_READ = 5'h11, OP_PUSH = 5'h12, OP_POP = 5'h13,
    OP_SLEEP = 5'h14, OP_WATCHDOG_RESTART = 5'h15
  } cbtc_op_t;

  typedef struct packed {
    cbtc_op_t op;
    logic [4:0] rd;
    logic [5:0] arg;
  } cbtc_instr_t;

  typedef struct packed {
    logic [15:0] addr;
    logic [7:0] wdata;
    logic we;
    logic re;
  } cbtc_dreq_t;

endpackage

// >>> cbtc_core.sv
// Executor for bit, data transfer and control instructions with an APB slave.
//
// Our own choices: the APB register port and the address map.
`timescale 1ns/100ps
`default_nettype none
module cbtc_core
  import cbtc_pkg::*;
(
  input wire logic mclk,
  input wire logic reset,
  input wire logic ce,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output cbtc_dreq_t dmem_req,
  input wire logic [7:0] dmem_rdata,
  output logic [15:0] pmem_addr,
  output logic pmem_re,
  input wire logic [7:0] pmem_rdata,
  output logic sleep_req,
  output logic wdt_restart,
  output logic irq_enable,
  output logic busy
);

  cbtc_instr_t ins_q;
  logic exec_q, pm_re_q, sleep_q, wdr_q;
  logic [1:0] cyc_q;
  logic [15:0] ext_q, sp_q, pm_addr_q;
  logic [7:0] flags_q;
  logic [4:0] sel_q;
  logic [7:0] gpr_q [0:31];
  cbtc_dreq_t dreq_q;
  logic [31:0] prdata_q;

  function automatic logic [4:0] ptr_base(input logic [1:0] sel);
    case (sel)
      PTR_X: ptr_base = REG_X_LO;
      PTR_Y: ptr_base = REG_Y_LO;
      default: ptr_base = REG_Z_LO;
    endcase
  endfunction

  function automatic logic [1:0] op_cycles(input cbtc_op_t op);
    case (op)
      OP_MEM_READ_IND, OP_MEM_WRITE_IND, OP_READ_DISP_Y, OP_READ_DISP_Z,
      OP_WRITE_DISP_Y, OP_WRITE_DISP_Z, OP_MEM_READ_DIRECT,
      OP_MEM_WRITE_DIRECT, OP_PUSH, OP_POP: op_cycles = CYC_MEM;
      OP_PROGRAM_MEMORY_READ: op_cycles = CYC_PM;
      default: op_cycles = CYC_ONE;
    endcase
  endfunction

  // APB decode. Writes that would disturb a running instruction are refused.
  logic apb_access, addr_ok, wr_refused, apb_wr;
  always_comb begin
    apb_access = psel && penable;
    case (paddr)
      ADDR_INSTR, ADDR_EXT, ADDR_FLAGS, ADDR_SP, ADDR_GPR_SEL,
      ADDR_GPR_DATA, ADDR_STATUS: addr_ok = 1'b1;
      default: addr_ok = 1'b0;
    endcase
    wr_refused = pwrite && ((exec_q && paddr != ADDR_GPR_SEL) || paddr == ADDR_STATUS);
    apb_wr = apb_access && pwrite && addr_ok && !wr_refused;
  end

  assign pready = ce;
  assign pslverr = apb_access && (!addr_ok || wr_refused);
  assign prdata = prdata_q;

  // Read data is captured in the setup cycle so it leaves a flip-flop.
  always_ff @(posedge mclk) begin
    if (reset) begin
      prdata_q <= 32'h0000_0000;
    end else if (ce && psel && !penable) begin
      case (paddr)
        ADDR_EXT: prdata_q <= {16'h0000, ext_q};
        ADDR_FLAGS: prdata_q <= {24'h00_0000, flags_q};
        ADDR_SP: prdata_q <= {16'h0000, sp_q};
        ADDR_GPR_SEL: prdata_q <= {27'h0, sel_q};
        ADDR_GPR_DATA: prdata_q <= {24'h00_0000, gpr_q[sel_q]};
        ADDR_STATUS: prdata_q <= {31'h0, exec_q};
        default: prdata_q <= 32'h0000_0000;
      endcase
    end
  end

  // Operand decode for the instruction held in ins_q.
  logic first, last, is_disp;
  logic [7:0] rd_val, flag_mask, ssr_val;
  logic [2:0] bit_idx;
  logic [1:0] mode, ptr_sel;
  logic [4:0] ptr_idx;
  logic [15:0] ptr_val;
  always_comb begin
    first = exec_q && cyc_q == 2'h0;
    last = exec_q && cyc_q == op_cycles(ins_q.op) - CYC_ONE;
    rd_val = gpr_q[ins_q.rd];
    bit_idx = ins_q.arg[2:0];
    mode = ins_q.arg[3:2];
    flag_mask = 8'h01 << bit_idx;
    ssr_val = {rd_val[7], rd_val[7:1]};
    is_disp = ins_q.op inside {OP_READ_DISP_Y, OP_READ_DISP_Z,
                               OP_WRITE_DISP_Y, OP_WRITE_DISP_Z};
    case (ins_q.op)
      OP_MEM_READ_IND, OP_MEM_WRITE_IND: ptr_sel = ins_q.arg[1:0];
      OP_READ_DISP_Y, OP_WRITE_DISP_Y: ptr_sel = PTR_Y;
      default: ptr_sel = PTR_Z;
    endcase
    ptr_idx = ptr_base(ptr_sel);
    ptr_val = {gpr_q[ptr_idx | 5'h01], gpr_q[ptr_idx]};
  end

  // Data memory address for the first cycle of a transfer.
  logic [15:0] mem_addr;
  logic mem_rd, mem_wr;
  always_comb begin
    mem_rd = 1'b0;
    mem_wr = 1'b0;
    case (ins_q.op)
      OP_MEM_READ_IND, OP_MEM_WRITE_IND: begin
        mem_addr = (mode == MODE_PRE_DEC) ? ptr_val - 16'h0001 : ptr_val;
        mem_rd = ins_q.op == OP_MEM_READ_IND;
        mem_wr = !mem_rd;
      end
      OP_READ_DISP_Y, OP_READ_DISP_Z, OP_WRITE_DISP_Y, OP_WRITE_DISP_Z: begin
        mem_addr = ptr_val + {10'h0, ins_q.arg};
        mem_rd = ins_q.op inside {OP_READ_DISP_Y, OP_READ_DISP_Z};
        mem_wr = !mem_rd;
      end
      OP_MEM_READ_DIRECT, OP_MEM_WRITE_DIRECT: begin
        mem_addr = ext_q;
        mem_rd = ins_q.op == OP_MEM_READ_DIRECT;
        mem_wr = !mem_rd;
      end
      OP_PUSH, OP_POP: begin
        mem_addr = (ins_q.op == OP_POP) ? sp_q + 16'h0001 : sp_q;
        mem_rd = ins_q.op == OP_POP;
        mem_wr = !mem_rd;
      end
      default: mem_addr = ptr_val;
    endcase
  end

  // Register file write ports: one byte port and one even-aligned pair port.
  logic bw_en, pw_en;
  logic [4:0] bw_idx, pw_idx;
  logic [7:0] bw_val;
  logic [15:0] pw_val;
  always_comb begin
    bw_en = 1'b0;
    bw_idx = ins_q.rd;
    bw_val = rd_val;
    pw_en = 1'b0;
    pw_idx = ptr_idx;
    pw_val = ptr_val + 16'h0001;
    if (first) begin
      case (ins_q.op)
        OP_SIGNED_SHIFT_RIGHT: begin
          bw_en = 1'b1;
          bw_val = ssr_val;
        end
        OP_NIBBLE_SWAP: begin
          bw_en = 1'b1;
          bw_val = {rd_val[3:0], rd_val[7:4]};
        end
        OP_TRANSFER_FLAG_TO_BIT: begin
          bw_en = 1'b1;
          bw_val = flags_q[FLAG_T] ? (rd_val | flag_mask) : (rd_val & ~flag_mask);
        end
        OP_COPY: begin
          bw_en = 1'b1;
          bw_val = gpr_q[ins_q.arg[4:0]];
        end
        OP_REGISTER_PAIR_COPY: begin
          pw_en = 1'b1;
          pw_idx = {ins_q.rd[4:1], 1'b0};
          pw_val = {gpr_q[{ins_q.arg[4:1], 1'b1}], gpr_q[{ins_q.arg[4:1], 1'b0}]};
        end
        OP_MEM_READ_IND, OP_MEM_WRITE_IND: begin
          pw_en = mode == MODE_POST_INC || mode == MODE_PRE_DEC;
          pw_val = (mode == MODE_PRE_DEC) ? ptr_val - 16'h0001 : ptr_val + 16'h0001;
        end
        OP_PROGRAM_MEMORY_READ: pw_en = mode == MODE_POST_INC;
        default: pw_en = 1'b0;
      endcase
    end else if (last) begin
      case (ins_q.op)
        OP_MEM_READ_IND, OP_READ_DISP_Y, OP_READ_DISP_Z, OP_MEM_READ_DIRECT, OP_POP: begin
          bw_en = 1'b1;
          bw_val = dmem_rdata;
        end
        OP_PROGRAM_MEMORY_READ: begin
          bw_en = 1'b1;
          bw_idx = (mode == MODE_TO_R0) ? REG_ZERO : ins_q.rd;
          bw_val = pmem_rdata;
        end
        default: bw_en = 1'b0;
      endcase
    end
  end

  // A result byte that lands on the pointer just updated wins over the pointer.
  always_ff @(posedge mclk) begin
    if (reset) begin
      for (int i = 0; i < 32; i++) begin
        gpr_q[i] <= GPR_RST;
      end
    end else if (ce) begin
      if (apb_wr && paddr == ADDR_GPR_DATA) begin
        gpr_q[sel_q] <= pwdata[7:0];
      end
      if (pw_en) begin
        gpr_q[pw_idx] <= pw_val[7:0];
        gpr_q[pw_idx | 5'h01] <= pw_val[15:8];
      end
      if (bw_en) begin
        gpr_q[bw_idx] <= bw_val;
      end
    end
  end

  // Sequencer: an instruction word written while idle starts execution.
  always_ff @(posedge mclk) begin
    if (reset) begin
      exec_q <= 1'b0;
      cyc_q <= 2'h0;
      ins_q <= '0;
    end else if (ce) begin
      if (apb_wr && paddr == ADDR_INSTR) begin
        ins_q <= pwdata[15:0];
        exec_q <= 1'b1;
        cyc_q <= 2'h0;
      end else if (last) begin
        exec_q <= 1'b0;
        cyc_q <= 2'h0;
      end else if (exec_q) begin
        cyc_q <= cyc_q + 2'h1;
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      ext_q <= 16'h0000;
      sel_q <= 5'h00;
    end else if (ce && apb_wr) begin
      if (paddr == ADDR_EXT) begin
        ext_q <= pwdata[15:0];
      end
      if (paddr == ADDR_GPR_SEL) begin
        sel_q <= pwdata[4:0];
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      flags_q <= FLAGS_RST;
    end else if (ce) begin
      if (apb_wr && paddr == ADDR_FLAGS) begin
        flags_q <= pwdata[7:0];
      end else if (first) begin
        case (ins_q.op)
          OP_FLAG_SET: flags_q <= flags_q | flag_mask;
          OP_FLAG_CLEAR: flags_q <= flags_q & ~flag_mask;
          OP_BIT_TO_TRANSFER_FLAG: flags_q[FLAG_T] <= rd_val[bit_idx];
          OP_SIGNED_SHIFT_RIGHT: begin
            flags_q[FLAG_C] <= rd_val[0];
            flags_q[FLAG_Z] <= ssr_val == 8'h00;
            flags_q[FLAG_N] <= ssr_val[7];
            flags_q[FLAG_V] <= ssr_val[7] ^ rd_val[0];
          end
          default: flags_q <= flags_q;
        endcase
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      sp_q <= SP_RST;
    end else if (ce) begin
      if (apb_wr && paddr == ADDR_SP) begin
        sp_q <= pwdata[15:0];
      end else if (first && ins_q.op == OP_PUSH) begin
        sp_q <= sp_q - 16'h0001;
      end else if (first && ins_q.op == OP_POP) begin
        sp_q <= sp_q + 16'h0001;
      end
    end
  end

  // Memory strobes last one cycle; the address is held afterwards.
  always_ff @(posedge mclk) begin
    if (reset) begin
      dreq_q <= '0;
      pm_addr_q <= 16'h0000;
      pm_re_q <= 1'b0;
    end else if (ce) begin
      dreq_q.we <= first && mem_wr;
      dreq_q.re <= first && mem_rd;
      pm_re_q <= first && ins_q.op == OP_PROGRAM_MEMORY_READ;
      if (first && (mem_wr || mem_rd)) begin
        dreq_q.addr <= mem_addr;
        dreq_q.wdata <= rd_val;
      end
      if (first && ins_q.op == OP_PROGRAM_MEMORY_READ) begin
        pm_addr_q <= ptr_val;
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      sleep_q <= 1'b0;
      wdr_q <= 1'b0;
    end else if (ce) begin
      sleep_q <= first && ins_q.op == OP_SLEEP;
      wdr_q <= first && ins_q.op == OP_WATCHDOG_RESTART;
    end
  end

  assign dmem_req = dreq_q;
  assign pmem_addr = pm_addr_q;
  assign pmem_re = pm_re_q;
  assign sleep_req = sleep_q;
  assign wdt_restart = wdr_q;
  assign irq_enable = flags_q[FLAG_I];
  assign busy = exec_q;

  default clocking cb @(posedge mclk); endclocking
  default disable iff (reset || !ce);

  sequence s_issue(cbtc_op_t op);
    first && ins_q.op == op;
  endsequence
  sequence s_read_tail;
    dreq_q.re && exec_q ##1 !exec_q;
  endsequence

  chk_bit_copy: assert property (s_issue(OP_BIT_TO_TRANSFER_FLAG) |=>
    flags_q[FLAG_T] == $past(rd_val[bit_idx]) &&
    (flags_q | 8'h40) == ($past(flags_q) | 8'h40))
    else $error("bit copy into T flag wrong");
  chk_bit_insert: assert property (s_issue(OP_TRANSFER_FLAG_TO_BIT) |=>
    gpr_q[$past(ins_q.rd)][$past(bit_idx)] == $past(flags_q[FLAG_T]) && $stable(flags_q))
    else $error("T flag not placed in register bit");
  chk_flag_ops: assert property (
    (s_issue(OP_FLAG_SET) |=> flags_q == ($past(flags_q) | $past(flag_mask)) && !exec_q) and
    (s_issue(OP_FLAG_CLEAR) |=> flags_q == ($past(flags_q) & ~$past(flag_mask))))
    else $error("flag set or clear changed wrong bits");
  chk_post_inc: assert property (first && mode == MODE_POST_INC &&
    ins_q.op inside {OP_MEM_READ_IND, OP_MEM_WRITE_IND} |=>
    dreq_q.addr == $past(ptr_val) && ptr_val == $past(ptr_val) + 16'h0001 ##1 !exec_q)
    else $error("post-increment address or pointer wrong");
  chk_pre_dec: assert property (first && mode == MODE_PRE_DEC &&
    ins_q.op inside {OP_MEM_READ_IND, OP_MEM_WRITE_IND} |=>
    dreq_q.addr == $past(ptr_val) - 16'h0001 && ptr_val == dreq_q.addr)
    else $error("pre-decrement address or pointer wrong");
  chk_disp_addr: assert property (first && is_disp |=>
    dreq_q.addr == $past(ptr_val) + {10'h0, $past(ins_q.arg)} && $stable(ptr_val))
    else $error("displaced address wrong or pointer moved");
  chk_load_data: assert property (dreq_q.re |-> s_read_tail ##0
    gpr_q[$past(ins_q.rd)] == $past(dmem_rdata))
    else $error("loaded byte not written in second cycle");
  chk_direct_store: assert property (s_issue(OP_MEM_WRITE_DIRECT) |=>
    dreq_q.we && dreq_q.addr == $past(ext_q) && $stable(flags_q) ##1 !exec_q)
    else $error("direct write address or timing wrong");
  chk_pm_read: assert property (s_issue(OP_PROGRAM_MEMORY_READ) |=>
    pmem_re && pmem_addr == $past(ptr_val) ##1 exec_q ##1 !exec_q)
    else $error("program read timing or address wrong");
  chk_push_stack: assert property (s_issue(OP_PUSH) |=>
    dreq_q.we && dreq_q.addr == $past(sp_q) && sp_q == $past(sp_q) - 16'h0001 ##1 !exec_q)
    else $error("push address or stack pointer wrong");
  chk_ctrl_pulses: assert property (
    (s_issue(OP_SLEEP) |=> sleep_req && $stable(flags_q) && !exec_q) and
    (s_issue(OP_WATCHDOG_RESTART) |=> wdt_restart && $stable(flags_q) && !exec_q))
    else $error("sleep or watchdog pulse missing");
  chk_shift_flags: assert property (s_issue(OP_SIGNED_SHIFT_RIGHT) |=>
    gpr_q[$past(ins_q.rd)] == {$past(rd_val[7]), $past(rd_val[7:1])} &&
    flags_q[FLAG_C] == $past(rd_val[0]))
    else $error("signed shift result or carry wrong");
  chk_swap_nibble: assert property (s_issue(OP_NIBBLE_SWAP) |=>
    gpr_q[$past(ins_q.rd)] == {$past(rd_val[3:0]), $past(rd_val[7:4])} && !exec_q)
    else $error("nibble swap wrong");

endmodule
`default_nettype wire

// >>> cbtc_mem_model.sv
// Behavioural data memory, stack and program memory facing the executor.
`timescale 1ns/100ps
`default_nettype none
module cbtc_mem_model
  import cbtc_pkg::*;
(
  input wire logic mclk,
  input wire cbtc_dreq_t dmem_req,
  output logic [7:0] dmem_rdata,
  input wire logic [15:0] pmem_addr,
  input wire logic pmem_re,
  output logic [7:0] pmem_rdata
);
  logic [7:0] dm [0:65535];
  logic [7:0] pm_q = 8'h00;
  logic pm_v = 1'b0;
  initial begin
    for (int i = 0; i < 65536; i++) begin
      dm[i] = 8'(i ^ (i >> 8) ^ 8'h3C);
    end
  end
  // Outside a read the lines show the inverse, so a late sample never matches by luck.
  assign dmem_rdata = dmem_req.re ? dm[dmem_req.addr] : ~dm[dmem_req.addr];
  assign pmem_rdata = pm_v ? pm_q : ~pm_q;
  always @(posedge mclk) begin
    if (dmem_req.we) begin
      dm[dmem_req.addr] <= dmem_req.wdata;
    end
    pm_v <= pmem_re;
    if (pmem_re) begin
      pm_q <= pmem_addr[7:0] + pmem_addr[15:8] + 8'h5A;
    end
  end
endmodule
`default_nettype wire

// >>> cpu_bit_transfer_control_ops_test.sv
// Self-checking bench for the bit, transfer and control executor.
`timescale 1ns/100ps
`default_nettype none
module cpu_bit_transfer_control_ops_test;
  import cbtc_pkg::*;
  logic mclk, reset, ce, psel, penable, pwrite, pready, pslverr, pmem_re;
  logic sleep_req, wdt_restart, irq_enable, busy;
  logic [7:0] paddr, dmem_rdata, pmem_rdata, last_d, fl;
  logic [31:0] pwdata, prdata;
  logic [15:0] pmem_addr, last_a, last_p, sp;
  cbtc_dreq_t dmem_req;
  int err_total, compares, seed, stall, n_mem, n_pm, n_slp, n_wdt;
  logic [7:0] rf [32];
  logic [7:0] mdm [int];
  cbtc_op_t dop [4] = '{OP_WRITE_DISP_Y, OP_WRITE_DISP_Z, OP_READ_DISP_Y, OP_READ_DISP_Z};

  cbtc_core uut (.mclk(mclk), .reset(reset), .ce(ce), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .dmem_req(dmem_req), .dmem_rdata(dmem_rdata),
    .pmem_addr(pmem_addr), .pmem_re(pmem_re), .pmem_rdata(pmem_rdata),
    .sleep_req(sleep_req), .wdt_restart(wdt_restart), .irq_enable(irq_enable),
    .busy(busy));
  cbtc_mem_model mem (.mclk(mclk), .dmem_req(dmem_req), .dmem_rdata(dmem_rdata),
    .pmem_addr(pmem_addr), .pmem_re(pmem_re), .pmem_rdata(pmem_rdata));

  initial begin
    mclk = 1'b0;
    forever #12.5 mclk = ~mclk;
  end

  // Sampled mid-cycle; an unknown strobe counts as a pulse so it cannot hide.
  always @(negedge mclk) begin
    if (dmem_req.re !== 1'b0 || dmem_req.we !== 1'b0) begin
      n_mem++;
      last_a = dmem_req.addr;
      last_d = dmem_req.wdata;
    end
    if (pmem_re !== 1'b0) begin
      n_pm++;
      last_p = pmem_addr;
    end
    if (sleep_req !== 1'b0) n_slp++;
    if (wdt_restart !== 1'b0) n_wdt++;
  end

  function automatic int rnd(input int n);
    return $unsigned($random(seed)) % n;
  endfunction

  function automatic logic [7:0] mget(input logic [15:0] a);
    return mdm.exists(a) ? mdm[a] : a[7:0] ^ a[15:8] ^ 8'h3C;
  endfunction

  task automatic close_out();
    if (err_total == 0 && compares > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] want);
    compares++;
    if (seen !== want) begin
      err_total++;
      $display("wrong value at %0t: saw %h, expected %h", $time, seen, want);
    end
  endtask

  // Select stays up after a transfer; each setup assigns it again, and run drops it itself.
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] r, output logic e);
    logic got;
    got = 1'b0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    if (stall > 0) ce <= 1'b0;
    while (!got) begin
      @(posedge mclk);
      got = pready === 1'b1;
      r = prdata;
      e = pslverr;
      if (--stall == 0) ce <= 1'b1;
    end
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic ee);
    logic [31:0] r;
    logic e;
    apb(1'b1, a, d, r, e);
    check(e, ee);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] want, input logic ee);
    logic [31:0] r;
    logic e;
    apb(1'b0, a, 32'h0, r, e);
    check(r, want);
    check(e, ee);
  endtask

  task automatic setreg(input int i, input logic [7:0] v);
    rf[i] = v;
    wr(ADDR_GPR_SEL, i, 1'b0);
    wr(ADDR_GPR_DATA, v, 1'b0);
  endtask

  task automatic verify();
    rd(ADDR_FLAGS, {24'h0, fl}, 1'b0);
    rd(ADDR_SP, {16'h0, sp}, 1'b0);
    check(irq_enable, fl[FLAG_I]);
    for (int i = 0; i < 32; i++) begin
      wr(ADDR_GPR_SEL, i, 1'b0);
      rd(ADDR_GPR_DATA, {24'h0, rf[i]}, 1'b0);
    end
  endtask

  task automatic run(input cbtc_op_t op, input logic [4:0] d, input logic [5:0] g,
                     input int cyc, input int mem, input int pm);
    int n, m0, p0, s0, w0;
    n = 0;
    m0 = n_mem;
    p0 = n_pm;
    s0 = n_slp;
    w0 = n_wdt;
    wr(ADDR_INSTR, {16'h0, op, d, g}, 1'b0);
    psel <= 1'b0;
    @(negedge mclk);
    while (busy !== 1'b0 && n < 8) begin
      n++;
      @(negedge mclk);
    end
    @(posedge mclk);
    check(n, cyc);
    check(n_mem - m0, mem);
    check(n_pm - p0, pm);
    check(n_slp - s0, op == OP_SLEEP);
    check(n_wdt - w0, op == OP_WATCHDOG_RESTART);
    verify();
  endtask

  task automatic mstep(input cbtc_op_t op, input int w, input int d, input logic [15:0] a,
                       input logic [5:0] g);
    if (w) mdm[a] = rf[d];
    else rf[d] = mget(a);
    run(op, 5'(d), g, 2, 1, 0);
    check(last_a, a);
    if (w) check(last_d, rf[d]);
  endtask

  initial begin
    repeat (60000) @(posedge mclk);
    err_total++;
    close_out();
  end

  initial begin
    logic [15:0] a, ptr;
    logic [7:0] v;
    int d, p, m, k, pl, rr, q;
    cbtc_op_t op;
    reset = 1'b1;
    ce = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    seed = 32'h323b;
    fl = FLAGS_RST;
    sp = SP_RST;
    for (int i = 0; i < 32; i++) rf[i] = GPR_RST;
    repeat (8) @(posedge mclk);
    reset <= 1'b0;
    @(posedge mclk);
    verify();
    rd(ADDR_STATUS, 32'h0, 1'b0);
    rd(8'h1C, 32'h0, 1'b1);
    wr(ADDR_STATUS, 32'h1, 1'b1);
    stall = 3;
    rd(ADDR_SP, {16'h0, sp}, 1'b0);
    for (int i = 0; i < 32; i++) setreg(i, 8'(rnd(256)));
    for (int s = 0; s < 8; s++) begin
      fl = 8'(rnd(256));
      wr(ADDR_FLAGS, fl, 1'b0);
      fl[s] = 1'b1;
      run(OP_FLAG_SET, 5'h00, 6'(s), 1, 0, 0);
      fl[s] = 1'b0;
      run(OP_FLAG_CLEAR, 5'h00, 6'(s), 1, 0, 0);
    end
    repeat (6) begin
      d = rnd(32);
      k = rnd(8);
      fl[FLAG_T] = rf[d][k];
      run(OP_BIT_TO_TRANSFER_FLAG, 5'(d), 6'(k), 1, 0, 0);
      d = rnd(32);
      k = rnd(8);
      rf[d][k] = fl[FLAG_T];
      run(OP_TRANSFER_FLAG_TO_BIT, 5'(d), 6'(k), 1, 0, 0);
    end
    setreg(5, 8'h01);
    for (int i = 0; i < 4; i++) begin
      d = (i == 0) ? 5 : rnd(32);
      v = rf[d];
      rf[d] = {v[7], v[7:1]};
      fl[FLAG_C] = v[0];
      fl[FLAG_Z] = rf[d] == 8'h00;
      fl[FLAG_N] = v[7];
      fl[FLAG_V] = v[7] ^ v[0];
      run(OP_SIGNED_SHIFT_RIGHT, 5'(d), 6'h00, 1, 0, 0);
      d = rnd(32);
      rf[d] = {rf[d][3:0], rf[d][7:4]};
      run(OP_NIBBLE_SWAP, 5'(d), 6'h00, 1, 0, 0);
      d = 2 * rnd(16);
      rr = 2 * rnd(16);
      {rf[d + 1], rf[d]} = {rf[rr + 1], rf[rr]};
      run(OP_REGISTER_PAIR_COPY, 5'(d), 6'(rr), 1, 0, 0);
      d = rnd(32);
      rr = rnd(32);
      rf[d] = rf[rr];
      run(OP_COPY, 5'(d), 6'(rr), 1, 0, 0);
      run(OP_NOP, 5'(d), 6'h00, 1, 0, 0);
    end
    // The X pointer starts at the top so both wrap directions are crossed.
    setreg(26, 8'hFF);
    setreg(27, 8'hFF);
    for (int w = 1; w >= 0; w--) begin
      for (int i = 0; i < 9; i++) begin
        p = i / 3 + 1;
        m = i % 3;
        k = m * 4 + p;
        pl = 24 + 2 * p;
        ptr = {rf[pl + 1], rf[pl]};
        if (m == 2) ptr--;
        a = ptr;
        if (m == 1) ptr++;
        {rf[pl + 1], rf[pl]} = ptr;
        op = w ? OP_MEM_WRITE_IND : OP_MEM_READ_IND;
        mstep(op, w, rnd(24), a, 6'(k));
      end
    end
    for (int i = 0; i < 8; i++) begin
      pl = (i % 2) ? 30 : 28;
      q = (i < 4) ? 63 : rnd(64);
      a = {rf[pl + 1], rf[pl]} + 16'(q);
      mstep(dop[i % 4], (i % 4) < 2, rnd(32), a, 6'(q));
    end
    for (int i = 0; i < 4; i++) begin
      if (i % 2 == 0) a = 16'(rnd(65536));
      wr(ADDR_EXT, a, 1'b0);
      op = (i % 2) ? OP_MEM_READ_DIRECT : OP_MEM_WRITE_DIRECT;
      mstep(op, i % 2 == 0, rnd(32), a, 6'h00);
    end
    for (int i = 0; i < 3; i++) begin
      m = (i == 2) ? 3 : i;
      ptr = {rf[31], rf[30]};
      k = rnd(24);
      rf[(m == 3) ? 0 : k] = ptr[7:0] + ptr[15:8] + 8'h5A;
      if (m == 1) {rf[31], rf[30]} = ptr + 16'h1;
      run(OP_PROGRAM_MEMORY_READ, 5'(k), 6'(m * 4), 3, 0, 1);
      check(last_p, ptr);
    end
    sp = 16'h0001;
    wr(ADDR_SP, sp, 1'b0);
    for (int i = 0; i < 4; i++) begin
      if (i < 2) begin
        a = sp;
        sp--;
        mstep(OP_PUSH, 1, rnd(32), a, 6'h00);
      end else begin
        sp++;
        mstep(OP_POP, 0, rnd(32), sp, 6'h00);
      end
    end
    run(OP_SLEEP, 5'h00, 6'h00, 1, 0, 0);
    run(OP_WATCHDOG_RESTART, 5'h00, 6'h00, 1, 0, 0);
    run(cbtc_op_t'(5'h1F), 5'h03, 6'h3F, 1, 0, 0);
    // A flag write during a three-cycle read must bounce and leave the flags alone.
    wr(ADDR_INSTR, {16'h0, OP_PROGRAM_MEMORY_READ, 5'h07, 6'h0C}, 1'b0);
    wr(ADDR_FLAGS, 32'hFF, 1'b1);
    psel <= 1'b0;
    rf[0] = rf[30] + rf[31] + 8'h5A;
    repeat (3) @(posedge mclk);
    verify();
    close_out();
  end
endmodule
`default_nettype wire
